/* verilog/asms_pkg.sv */
// Package: register map, field positions and constants of the serial mode/status block
package asms_pkg;
  // ==========================================================
  // Register offsets (word index on the plain register port)
  localparam logic [2:0] OFF_MODE = 3'h0;
  localparam logic [2:0] OFF_STAT = 3'h1;
  localparam logic [2:0] OFF_TXDATA = 3'h2;
  localparam logic [2:0] OFF_RXDATA = 3'h3;
  localparam logic [2:0] OFF_DIVISOR = 3'h4;
  localparam logic [2:0] OFF_EVENTS = 3'h5;
  // ==========================================================
  // Mode register fields
  localparam int MODE_ON = 15;
  localparam int MODE_IDLE_STOP = 13;
  localparam int MODE_IR_ON = 12;
  localparam int MODE_RTS_MODE = 11;
  localparam int MODE_PINS_LO = 8;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOPBACK = 6;
  localparam int MODE_AUTO_RATE = 5;
  localparam int MODE_RX_POL = 4;
  localparam int MODE_HIGH_SPEED = 3;
  localparam int MODE_FORMAT_LO = 1;
  localparam int MODE_STOP_SEL = 0;
  localparam logic [15:0] MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // ==========================================================
  // Status register fields
  localparam int STAT_TXI_HI = 15;
  localparam int STAT_TX_POL = 14;
  localparam int STAT_TXI_LO = 13;
  localparam int STAT_BREAK = 11;
  localparam int STAT_TX_ON = 10;
  localparam int STAT_TX_FULL = 9;
  localparam int STAT_SHIFT_EMPTY = 8;
  localparam int STAT_RXI_LO = 6;
  localparam int STAT_ADDR_DET = 5;
  localparam int STAT_RX_QUIET = 4;
  localparam int STAT_PARITY = 3;
  localparam int STAT_FRAMING = 2;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_RX_AVAIL = 0;
  // ==========================================================
  // Pin usage, formats, interrupt modes
  localparam logic [1:0] PINS_TXRX = 2'h0;
  localparam logic [1:0] PINS_RTS = 2'h1;
  localparam logic [1:0] PINS_RTS_CTS = 2'h2;
  localparam logic [1:0] PINS_BCLK = 2'h3;
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;
  localparam logic [1:0] TXI_EACH = 2'h0;
  localparam logic [1:0] TXI_DONE = 2'h1;
  localparam logic [1:0] TXI_EMPTY = 2'h2;
  localparam logic [1:0] RXI_THREE = 2'h2;
  localparam logic [1:0] RXI_FULL = 2'h3;
  // ==========================================================
  // Sizes and timing
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_DEPTH_C = 3'h4;
  localparam logic [2:0] RXI_THREE_COUNT = 3'h3;
  localparam logic [4:0] TICKS_STD = 5'h10;
  localparam logic [4:0] TICKS_FAST = 5'h04;
  localparam logic [3:0] BREAK_ZEROS = 4'hC;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [3:0] SYNC_EDGES = 4'h4;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
endpackage : asms_pkg

/* verilog/asms_queue.sv */
// Four-entry flip-flop FIFO used for transmit and receive characters
`timescale 1ns/1ps
`default_nettype none
module asms_queue (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic push,
  input wire logic [10:0] pushData,
  // Drain side
  input wire logic pop,
  output logic [10:0] headData,
  // State
  output logic [2:0] count
);
  logic [10:0] mem_r [asms_pkg::QUEUE_DEPTH];
  logic [1:0] wrPtr_r;
  logic [1:0] rdPtr_r;
  logic [2:0] count_r;
  logic doPush;
  logic doPop;

  assign doPop = pop && (count_r != 3'h0);
  assign doPush = push && ((count_r != asms_pkg::QUEUE_DEPTH_C) || doPop);
  assign headData = mem_r[rdPtr_r];
  assign count = count_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= 2'h0;
      rdPtr_r <= 2'h0;
      count_r <= 3'h0;
    end else if (flush) begin
      wrPtr_r <= 2'h0;
      rdPtr_r <= 2'h0;
      count_r <= 3'h0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 2'h1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 2'h1;
      end
      count_r <= count_r + {2'h0, doPush} - {2'h0, doPop};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < asms_pkg::QUEUE_DEPTH; i++) begin
        mem_r[i] <= 11'h000;
      end
    end else if (doPush) begin
      mem_r[wrPtr_r] <= pushData;
    end
  end
endmodule : asms_queue
`default_nettype wire

/* verilog/asms_serial.sv */
// Serial transceiver with mode and status control registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Enable hands pins to transceiver
// - Idle-stop halts module during idle
// - Infrared coding only in 16x mode
// - RTS simplex when set, flow otherwise
// - Pin-usage field picks active pins
// - Wake: edge interrupt, clears on rise
// - Loopback ties transmitter to receiver
// - Auto-rate measures sync char, self-clears
// - Receive polarity sets RX idle level
// - High speed: 4 ticks, else 16
// - Format field sets data and parity
// - Stop select gives two stop bits
// - Transmit interrupt mode selects event
// - Transmit polarity, reversed with infrared
// - Break: start, twelve zeros, stop
// - Transmit off aborts and flushes
// - Queue-full flag when four queued
// - Shift-empty when shifter and queue empty
// - Receive interrupt at 1, 3, 4
// - Both buffers four-entry FIFOs
// - Overrun clear flushes receiver
module asms_serial (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // Device power state
  input wire logic deviceIdle,
  input wire logic deviceSleep,
  // Serial pins
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutOe,
  input wire logic clearToSendPin,
  output logic requestToSendPin,
  output logic requestToSendOe,
  output logic baudClockPin,
  output logic baudClockOe,
  // Events
  output logic txIrq,
  output logic rxIrq,
  output logic wakeIrq
);
  // ==========================================================
  // Registers
  logic [15:0] mode_r;
  logic [15:0] divisor_r;
  logic txIrqMode1_r, txPol_r, txIrqMode0_r, sendBreak_r, txOn_r, addrDet_r;
  logic [1:0] rxIrqMode_r;
  logic parityFault_r, framingFault_r, overrunFault_r;
  logic [15:0] regRdData_r;
  logic txIrq_r, rxIrq_r, wakeIrq_r;

  logic moduleOn, run, irOn, fast, loop, autoRate, rxPol, stopTwo;
  logic [1:0] pinUsage, formatSel, txIrqMode;
  assign moduleOn = mode_r[asms_pkg::MODE_ON];
  assign run = moduleOn && !(mode_r[asms_pkg::MODE_IDLE_STOP] && deviceIdle);
  assign fast = mode_r[asms_pkg::MODE_HIGH_SPEED];
  assign irOn = mode_r[asms_pkg::MODE_IR_ON] && !fast;
  assign loop = mode_r[asms_pkg::MODE_LOOPBACK];
  assign autoRate = mode_r[asms_pkg::MODE_AUTO_RATE];
  assign rxPol = mode_r[asms_pkg::MODE_RX_POL];
  assign stopTwo = mode_r[asms_pkg::MODE_STOP_SEL];
  assign pinUsage = mode_r[asms_pkg::MODE_PINS_LO +: 2];
  assign formatSel = mode_r[asms_pkg::MODE_FORMAT_LO +: 2];
  assign txIrqMode = {txIrqMode1_r, txIrqMode0_r};

  // ==========================================================
  // Rate generator: one tick per sixteenth or quarter bit
  logic [15:0] divCnt_r;
  logic tick;
  logic [4:0] ticksPerBit;
  assign tick = run && (divCnt_r == 16'h0000);
  assign ticksPerBit = fast ? asms_pkg::TICKS_FAST : asms_pkg::TICKS_STD;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_r <= 16'h0000;
    end else if (!run || divCnt_r == 16'h0000) begin
      divCnt_r <= divisor_r;
    end else begin
      divCnt_r <= divCnt_r - 16'h0001;
    end
  end

  // ==========================================================
  // Queues
  logic txFlush, rxFlush, txPop, rxPush, rxPop, txPush;
  logic [10:0] txHead, rxHead, rxWord;
  logic [2:0] txCount, rxCount;
  logic overrunClear;
  assign txPush = regWrite && regAddr == asms_pkg::OFF_TXDATA;
  assign rxPop = regRead && regAddr == asms_pkg::OFF_RXDATA;
  assign txFlush = !txOn_r || !moduleOn;
  assign overrunClear = regWrite && regAddr == asms_pkg::OFF_STAT && overrunFault_r
    && !regWrData[asms_pkg::STAT_OVERRUN];
  assign rxFlush = overrunClear || !moduleOn;

  asms_queue txQueue (
    .clock(clock), .reset_n(reset_n), .flush(txFlush),
    .push(txPush), .pushData({2'h0, regWrData[8:0]}),
    .pop(txPop), .headData(txHead), .count(txCount)
  );
  asms_queue rxQueue (
    .clock(clock), .reset_n(reset_n), .flush(rxFlush),
    .push(rxPush), .pushData(rxWord),
    .pop(rxPop), .headData(rxHead), .count(rxCount)
  );

  function automatic logic parityOf(input logic [8:0] d, input logic [1:0] fmt);
    parityOf = (fmt == asms_pkg::FMT_8O) ? ~^d[7:0] : ^d[7:0];
  endfunction : parityOf

  function automatic logic [3:0] dataBits(input logic [1:0] fmt);
    dataBits = (fmt == asms_pkg::FMT_9N) ? 4'h9 : 4'h8;
  endfunction : dataBits

  // ==========================================================
  // Transmitter: frame is start, data LSB first, parity, stops
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asms_tx_t;
  asms_tx_t txState_r;
  logic [8:0] txShift_r;
  logic [3:0] txBit_r;
  logic [4:0] txTick_r;
  logic txLine_r, txIsBreak_r, txBitEnd, cts;
  assign cts = (pinUsage != asms_pkg::PINS_RTS_CTS) || !clearToSendPin;
  assign txBitEnd = tick && (txTick_r == ticksPerBit - 5'h01);
  assign txPop = run && txState_r == TX_IDLE && txCount != 3'h0 && cts;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txState_r <= TX_IDLE;
      txShift_r <= 9'h000;
      txBit_r <= 4'h0;
      txTick_r <= 5'h00;
      txLine_r <= 1'b1;
      txIsBreak_r <= 1'b0;
    end else if (txFlush) begin
      txState_r <= TX_IDLE;
      txLine_r <= 1'b1;
      txTick_r <= 5'h00;
    end else if (txPop) begin
      txState_r <= TX_START;
      txShift_r <= txHead[8:0];
      txIsBreak_r <= sendBreak_r;
      txLine_r <= 1'b0;
      txTick_r <= 5'h00;
      txBit_r <= 4'h0;
    end else if (tick) begin
      txTick_r <= txBitEnd ? 5'h00 : txTick_r + 5'h01;
      if (txBitEnd) begin
        unique case (txState_r)
          TX_IDLE: txLine_r <= 1'b1;
          TX_START: begin
            txState_r <= TX_DATA;
            txLine_r <= txIsBreak_r ? 1'b0 : txShift_r[0];
          end
          TX_DATA: begin
            txBit_r <= txBit_r + 4'h1;
            if (txIsBreak_r ? txBit_r == asms_pkg::BREAK_ZEROS - 4'h1
                : txBit_r == dataBits(formatSel) - 4'h1) begin
              if (!txIsBreak_r && formatSel != asms_pkg::FMT_8N
                  && formatSel != asms_pkg::FMT_9N) begin
                txState_r <= TX_PAR;
                txLine_r <= parityOf(txShift_r, formatSel);
              end else begin
                txState_r <= TX_STOP;
                txLine_r <= 1'b1;
                txBit_r <= 4'h0;
              end
            end else begin
              txLine_r <= txIsBreak_r ? 1'b0 : txShift_r[txBit_r + 4'h1];
            end
          end
          TX_PAR: begin
            txState_r <= TX_STOP;
            txLine_r <= 1'b1;
            txBit_r <= 4'h0;
          end
          TX_STOP: begin
            txBit_r <= txBit_r + 4'h1;
            if (txBit_r == {3'h0, stopTwo} || txIsBreak_r) begin
              txState_r <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end
  logic txDone;
  assign txDone = txBitEnd && txState_r == TX_STOP && (txBit_r == {3'h0, stopTwo} || txIsBreak_r);

  // ==========================================================
  // Receiver, with loopback and polarity on the input
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} asms_rx_t;
  asms_rx_t rxState_r;
  logic rxLine, rxLinePrev_r;
  logic [4:0] rxTick_r;
  logic [3:0] rxBit_r, rxLen;
  logic [9:0] rxShift_r;
  assign rxLine = loop ? txLine_r : (serialInPin ^ rxPol);
  assign rxLen = dataBits(formatSel)
    + ((formatSel == asms_pkg::FMT_8E || formatSel == asms_pkg::FMT_8O) ? 4'h1 : 4'h0);
  assign rxWord = {2'h0, formatSel == asms_pkg::FMT_9N ? rxShift_r[8:0]
    : {1'b0, formatSel == asms_pkg::FMT_8N ? rxShift_r[8:1] : rxShift_r[7:0]}};
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxState_r <= RX_IDLE;
      rxTick_r <= 5'h00;
      rxBit_r <= 4'h0;
      rxShift_r <= 10'h000;
      rxLinePrev_r <= 1'b1;
    end else begin
      rxLinePrev_r <= rxLine;
      if (rxFlush) begin
        rxState_r <= RX_IDLE;
      end else if (tick) begin
        rxTick_r <= (rxTick_r == ticksPerBit - 5'h01) ? 5'h00 : rxTick_r + 5'h01;
        unique case (rxState_r)
          RX_IDLE: if (!rxLine) begin
            rxState_r <= RX_BITS;
            rxTick_r <= 5'h00;
            rxBit_r <= 4'h0;
          end
          RX_BITS: if (rxTick_r == ticksPerBit - 5'h01) begin
            rxShift_r <= {rxLine, rxShift_r[9:1]};
            rxBit_r <= rxBit_r + 4'h1;
            if (rxBit_r == rxLen) begin
              rxState_r <= RX_STOP;
            end
          end
          RX_STOP: if (rxTick_r == (ticksPerBit >> 1)) begin
            rxState_r <= RX_IDLE;
          end
        endcase
      end
    end
  end
  logic rxDone, rxStopBad;
  assign rxDone = tick && rxState_r == RX_STOP && rxTick_r == (ticksPerBit >> 1) && !rxFlush;
  assign rxStopBad = !rxLine;
  assign rxPush = rxDone && !autoRate && rxCount != asms_pkg::QUEUE_DEPTH_C;

  // ==========================================================
  // Auto-rate: counts clocks from the first to the fifth falling edge of the sync character
  logic [19:0] measure_r;
  logic [3:0] edges_r;
  logic measureDone;
  assign measureDone = autoRate && run && edges_r == asms_pkg::SYNC_EDGES
    && rxLinePrev_r && !rxLine;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      measure_r <= 20'h00000;
      edges_r <= 4'h0;
    end else if (!autoRate || measureDone) begin
      measure_r <= 20'h00000;
      edges_r <= 4'h0;
    end else begin
      if (edges_r != 4'h0) begin
        measure_r <= measure_r + 20'h00001;
      end
      if (rxLinePrev_r && !rxLine) begin
        edges_r <= edges_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // Mode register, with hardware clears of wake and auto-rate
  logic wakeFall, wakeRise, modeWrite;
  assign modeWrite = regWrite && regAddr == asms_pkg::OFF_MODE;
  assign wakeFall = mode_r[asms_pkg::MODE_WAKE] && deviceSleep && rxLinePrev_r && !rxLine;
  assign wakeRise = mode_r[asms_pkg::MODE_WAKE] && !rxLinePrev_r && rxLine && wakeIrq_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= asms_pkg::MODE_RESET;
    end else begin
      if (modeWrite) begin
        mode_r <= regWrData & asms_pkg::MODE_WMASK;
      end
      if (wakeRise) begin
        mode_r[asms_pkg::MODE_WAKE] <= 1'b0;
      end
      if (measureDone) begin
        mode_r[asms_pkg::MODE_AUTO_RATE] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divisor_r <= asms_pkg::DIVISOR_RESET;
    end else if (measureDone) begin
      divisor_r <= 16'(measure_r >> (fast ? 5 : 7));
    end else if (regWrite && regAddr == asms_pkg::OFF_DIVISOR) begin
      divisor_r <= regWrData;
    end
  end

  // ==========================================================
  // Status register control bits and faults
  logic statWrite;
  assign statWrite = regWrite && regAddr == asms_pkg::OFF_STAT;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {txIrqMode1_r, txPol_r, txIrqMode0_r, txOn_r, addrDet_r} <= 5'h00;
      rxIrqMode_r <= 2'h0;
      sendBreak_r <= 1'b0;
    end else begin
      if (statWrite) begin
        txIrqMode1_r <= regWrData[asms_pkg::STAT_TXI_HI];
        txPol_r <= regWrData[asms_pkg::STAT_TX_POL];
        txIrqMode0_r <= regWrData[asms_pkg::STAT_TXI_LO];
        txOn_r <= regWrData[asms_pkg::STAT_TX_ON];
        rxIrqMode_r <= regWrData[asms_pkg::STAT_RXI_LO +: 2];
        addrDet_r <= regWrData[asms_pkg::STAT_ADDR_DET];
        sendBreak_r <= regWrData[asms_pkg::STAT_BREAK];
      end
      if (txDone && txIsBreak_r) begin
        sendBreak_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overrunFault_r <= 1'b0;
      parityFault_r <= 1'b0;
      framingFault_r <= 1'b0;
    end else begin
      if (rxDone && !autoRate && rxCount == asms_pkg::QUEUE_DEPTH_C) begin
        overrunFault_r <= 1'b1;
      end else if (overrunClear) begin
        overrunFault_r <= 1'b0;
      end
      if (rxPush) begin
        framingFault_r <= rxStopBad;
        parityFault_r <= (formatSel == asms_pkg::FMT_8E || formatSel == asms_pkg::FMT_8O)
          && (parityOf(rxShift_r[8:0], formatSel) != rxShift_r[8]);
      end
    end
  end

  // ==========================================================
  // Interrupt pulses for transmit and receive; wake event held as a level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txIrq_r <= 1'b0;
      rxIrq_r <= 1'b0;
      wakeIrq_r <= 1'b0;
    end else begin
      unique case (txIrqMode)
        asms_pkg::TXI_EACH: txIrq_r <= txPop;
        asms_pkg::TXI_DONE: txIrq_r <= txDone && txCount == 3'h0;
        asms_pkg::TXI_EMPTY: txIrq_r <= txPop && txCount == 3'h1;
        default: txIrq_r <= 1'b0;
      endcase
      unique case (rxIrqMode_r)
        asms_pkg::RXI_FULL: rxIrq_r <= rxPush && rxCount == asms_pkg::QUEUE_DEPTH_C - 3'h1;
        asms_pkg::RXI_THREE: rxIrq_r <= rxPush && rxCount == asms_pkg::RXI_THREE_COUNT - 3'h1;
        default: rxIrq_r <= rxPush;
      endcase
      if (wakeFall) begin
        wakeIrq_r <= 1'b1;
      end else if (wakeRise || !mode_r[asms_pkg::MODE_WAKE]) begin
        wakeIrq_r <= 1'b0;
      end
    end
  end
  assign txIrq = txIrq_r;
  assign rxIrq = rxIrq_r;
  assign wakeIrq = wakeIrq_r;

  // ==========================================================
  // Register reads, one cycle after the strobe
  logic shiftEmpty;
  assign shiftEmpty = txState_r == TX_IDLE && txCount == 3'h0;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_r <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        asms_pkg::OFF_MODE: regRdData_r <= mode_r;
        asms_pkg::OFF_STAT: regRdData_r <= {txIrqMode1_r, txPol_r, txIrqMode0_r, 1'b0,
          sendBreak_r, txOn_r, txCount == asms_pkg::QUEUE_DEPTH_C, shiftEmpty,
          rxIrqMode_r, addrDet_r, rxState_r == RX_IDLE, parityFault_r, framingFault_r,
          overrunFault_r, rxCount != 3'h0};
        asms_pkg::OFF_RXDATA: regRdData_r <= {7'h00, rxHead[8:0]};
        asms_pkg::OFF_DIVISOR: regRdData_r <= divisor_r;
        default: regRdData_r <= 16'h0000;
      endcase
    end else begin
      regRdData_r <= 16'h0000;
    end
  end
  assign regRdData = regRdData_r;

  // ==========================================================
  // Pin ownership; with module off all pins go back to the port
  logic txIdleHigh;
  assign txIdleHigh = irOn ? txPol_r : !txPol_r;
  assign serialOutPin = txIdleHigh ? txLine_r : !txLine_r;
  assign serialOutOe = moduleOn && txOn_r && !loop;
  assign requestToSendOe = moduleOn
    && (pinUsage == asms_pkg::PINS_RTS || pinUsage == asms_pkg::PINS_RTS_CTS);
  // Simplex: asserted while sending; flow control: asserted while room to receive
  assign requestToSendPin = mode_r[asms_pkg::MODE_RTS_MODE] ? (txState_r == TX_IDLE)
    : (rxCount == asms_pkg::QUEUE_DEPTH_C);
  assign baudClockOe = moduleOn && pinUsage == asms_pkg::PINS_BCLK;
  assign baudClockPin = txTick_r < (ticksPerBit >> 1);
endmodule : asms_serial
`default_nettype wire

/* verification/asms_serial_props.sv */
// Checker: port-level properties of the serial block
`timescale 1ns/1ps
`default_nettype none
module asms_serial_props (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  // Pins and events
  input wire logic serialOutOe,
  input wire logic requestToSendOe,
  input wire logic baudClockOe,
  input wire logic txIrq,
  input wire logic rxIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Shadow of written values; checks use only bits that hardware never clears
  logic [15:0] modeS;
  logic txOnS;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      modeS <= 16'h0000;
      txOnS <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == asms_pkg::OFF_MODE) modeS <= regWrData;
      if (regAddr == asms_pkg::OFF_STAT) txOnS <= regWrData[10];
    end
  end
  read_idle_a: assert property (!$past(regRead) |-> regRdData == 16'h0000)
    else $error("read data not zero outside read cycle");
  pins_off_a: assert property (!modeS[15] [*2] |-> !serialOutOe && !requestToSendOe)
    else $error("pin driven while module off");
  pins_none_a: assert property ((modeS[9:8] == 2'h0) [*2] |-> !baudClockOe)
    else $error("baud clock driven with tx/rx only");
  bclk_on_a: assert property ((modeS[15] && modeS[9:8] == 2'h3) [*2] |-> baudClockOe)
    else $error("baud clock not driven");
  rts_on_a: assert property ((modeS[15] && modeS[9:8] == 2'h1) [*2] |-> requestToSendOe)
    else $error("rts not driven");
  tx_off_a: assert property (!txOnS [*2] |-> !serialOutOe)
    else $error("tx driven while transmit off");
  tx_pulse_a: assert property (txIrq |=> !txIrq)
    else $error("tx event longer than one cycle");
  rx_pulse_a: assert property (rxIrq |=> !rxIrq)
    else $error("rx event longer than one cycle");
endmodule : asms_serial_props
bind asms_serial asms_serial_props u_props (.clock(clock), .reset_n(reset_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .serialOutOe(serialOutOe), .requestToSendOe(requestToSendOe),
  .baudClockOe(baudClockOe), .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire

/* verification/asms_remote.sv */
// Remote serial terminal model
`timescale 1ns/1ps
`default_nettype none
module asms_remote (
  // Clock
  input wire logic clock,
  // Lines
  input wire logic txLine,
  output logic rxLine
);
  int bc = 16;
  int lowRun = 0;
  int lastLow = 0;
  logic [8:0] got[$];
  logic [8:0] frame;
  initial rxLine = 1'b1;
  // Nine mid-bit samples after each start edge
  always begin
    @(negedge txLine);
    repeat (bc / 2) @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      repeat (bc) @(posedge clock);
      frame[i] = txLine;
    end
    got.push_back(frame);
  end
  always @(posedge clock) begin
    if (!txLine) begin
      lowRun <= lowRun + 1;
    end else begin
      if (lowRun != 0) lastLow <= lowRun;
      lowRun <= 0;
    end
  end
  task automatic send(input logic [7:0] d);
    rxLine <= 1'b0;
    repeat (bc) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      rxLine <= d[i];
      repeat (bc) @(posedge clock);
    end
    rxLine <= 1'b1;
    repeat (bc) @(posedge clock);
  endtask : send
endmodule : asms_remote
`default_nettype wire

/* verification/asms_serial_bench.sv */
// Testbench of the serial mode/status block
`timescale 1ns/1ps
`default_nettype none
module asms_serial_bench;
  logic clock, reset_n, regWrite, regRead, serialInPin, serialOutPin, serialOutOe;
  logic [2:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic requestToSendPin, requestToSendOe, baudClockPin, baudClockOe, txIrq, rxIrq, wakeIrq;
  wire logic txWire;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int txPulses = 0;
  int rxPulses = 0;
  // Released line has a pull-up
  assign txWire = (serialOutOe === 1'b1) ? serialOutPin : 1'b1;
  asms_serial u_dut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .deviceIdle(1'b0), .deviceSleep(1'b0), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .clearToSendPin(1'b0),
    .requestToSendPin(requestToSendPin), .requestToSendOe(requestToSendOe),
    .baudClockPin(baudClockPin), .baudClockOe(baudClockOe), .txIrq(txIrq), .rxIrq(rxIrq),
    .wakeIrq(wakeIrq));
  asms_remote u_remote (.clock(clock), .txLine(txWire), .rxLine(serialInPin));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    txPulses += int'(txIrq === 1'b1);
    rxPulses += int'(rxIrq === 1'b1);
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(what, regRdData, exp);
    @(posedge clock);
  endtask : rd
  task automatic waitGot(input int k);
    for (int n = 0; n < 3000 && u_remote.got.size() < k; n++) @(posedge clock);
  endtask : waitGot
  task automatic final_report();
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(asms_pkg::OFF_MODE, 16'h0000, "mode reset");
    rd(asms_pkg::OFF_STAT, 16'h0110, "status reset");
    rd(3'h7, 16'h0000, "unmapped");
    wr(asms_pkg::OFF_MODE, 16'hFF5F);
    rd(asms_pkg::OFF_MODE, 16'hBB5F, "mode mask");
    wr(asms_pkg::OFF_MODE, 16'h8100);
    wr(asms_pkg::OFF_STAT, 16'h2400);
    for (int f = 0; f < 4; f++) begin
      wr(asms_pkg::OFF_MODE, 16'h8000 | 16'(f << 1));
      wr(asms_pkg::OFF_TXDATA, 16'h00A5);
      rd(asms_pkg::OFF_STAT, 16'h2410, "busy");
      waitGot(1);
      chk("format", 16'(u_remote.got.pop_front()), {7'h00, ~f[0], 8'hA5});
      for (int n = 0; n < 300 && txPulses <= f; n++) @(posedge clock);
    end
    chk("tx events", 16'(txPulses), 16'h0004);
    wr(asms_pkg::OFF_STAT, 16'h0400);
    wr(asms_pkg::OFF_MODE, 16'h8000);
    for (int i = 0; i < 5; i++) wr(asms_pkg::OFF_TXDATA, 16'h0060 + 16'(i));
    rd(asms_pkg::OFF_STAT, 16'h0610, "full");
    waitGot(5);
    for (int i = 0; i < 5; i++) begin
      chk("order", 16'(u_remote.got.pop_front()), 16'h0160 + 16'(i));
    end
    repeat (32) @(posedge clock);
    wr(asms_pkg::OFF_STAT, 16'h0C00);
    wr(asms_pkg::OFF_TXDATA, 16'h0000);
    waitGot(1);
    repeat (80) @(posedge clock);
    chk("break low", 16'(u_remote.lastLow), 16'h00D0);
    rd(asms_pkg::OFF_STAT, 16'h0510, "break clear");
    u_remote.got.delete();
    wr(asms_pkg::OFF_MODE, 16'h8008);
    u_remote.bc = 4;
    wr(asms_pkg::OFF_TXDATA, 16'h003C);
    waitGot(1);
    chk("fast", 16'(u_remote.got.pop_front()), 16'h013C);
    wr(asms_pkg::OFF_MODE, 16'h8000);
    u_remote.bc = 16;
    wr(asms_pkg::OFF_STAT, 16'h0080);
    rxPulses = 0;
    for (int i = 0; i < 4; i++) u_remote.send(8'h30 + 8'(i));
    chk("rx events", 16'(rxPulses), 16'h0001);
    for (int i = 0; i < 4; i++) rd(asms_pkg::OFF_RXDATA, 16'h0030 + 16'(i), "rx data");
    wr(asms_pkg::OFF_STAT, 16'h00C0);
    rxPulses = 0;
    for (int i = 0; i < 5; i++) u_remote.send(8'h40 + 8'(i));
    chk("rx full", 16'(rxPulses), 16'h0001);
    chk("rts", 16'(requestToSendPin), 16'h0001);
    rd(asms_pkg::OFF_STAT, 16'h01D3, "overrun");
    wr(asms_pkg::OFF_STAT, 16'h00C0);
    rd(asms_pkg::OFF_STAT, 16'h01D0, "flushed");
    wr(asms_pkg::OFF_MODE, 16'h8040);
    wr(asms_pkg::OFF_STAT, 16'h0400);
    wr(asms_pkg::OFF_TXDATA, 16'h005A);
    repeat (200) @(posedge clock);
    rd(asms_pkg::OFF_RXDATA, 16'h005A, "loopback");
    wr(asms_pkg::OFF_MODE, 16'h8020);
    u_remote.send(8'h55);
    repeat (20) @(posedge clock);
    rd(asms_pkg::OFF_MODE, 16'h8000, "auto-rate");
    rd(asms_pkg::OFF_DIVISOR, 16'h0000, "divisor");
    final_report();
  end
endmodule : asms_serial_bench
`default_nettype wire
